/* File: logic/ext_cap_pkg.sv */
// Package: offsets, field layouts and reset values of the extended capability registers
package ext_cap_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_HDR_LOG_W1 = 12'h11c;
  localparam logic [11:0] OFF_HDR_LOG_W2 = 12'h120;
  localparam logic [11:0] OFF_HDR_LOG_W3 = 12'h124;
  localparam logic [11:0] OFF_HDR_LOG_W4 = 12'h128;
  localparam logic [11:0] OFF_SERIAL_CAP_HEADER = 12'h180;
  localparam logic [11:0] OFF_UNIQUE_ID_LOW = 12'h184;
  localparam logic [11:0] OFF_UNIQUE_ID_HIGH = 12'h188;
  localparam logic [11:0] OFF_CHANNEL_CAP_HEADER = 12'h200;
  localparam logic [11:0] OFF_PORT_CHANNEL_CAPS_ONE = 12'h204;
  localparam logic [11:0] OFF_LOAD_CTRL = 12'h3f0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CAP_ID_LSB = 0;
  localparam int CAP_ID_W = 16;
  localparam int CAP_VER_LSB = 16;
  localparam int CAP_VER_W = 4;
  localparam int NEXT_OFF_LSB = 20;
  localparam int NEXT_OFF_W = 12;
  localparam int EXTRA_CNT_LSB = 0;
  localparam int LOW_PRIO_CNT_LSB = 4;
  localparam int WRR_BASE_LSB = 8;
  localparam int ARB_SIZE_LSB = 10;
  localparam int LOAD_LOCK_BIT = 0;

  // ----------------------------------------------------------------
  // Fixed and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] SERIAL_CAP_ID = 16'h0003;
  localparam logic [15:0] CHANNEL_CAP_ID = 16'h0002;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] SERIAL_NEXT_RESET = 12'h200;
  localparam logic [11:0] CHANNEL_NEXT_RESET = 12'h000;
  localparam logic [2:0] EXTRA_CNT_RESET = 3'h0;
  localparam logic [2:0] LOW_PRIO_CNT_RESET = 3'h0;
  localparam logic [1:0] WRR_BASE_VALUE = 2'h0;
  localparam logic [1:0] ARB_SIZE_RESET = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Arbitration table entry size encodings
  typedef enum logic [1:0] {ARB_1BIT, ARB_2BIT, ARB_4BIT, ARB_8BIT} arb_size_e;

endpackage : ext_cap_pkg

/* File: logic/header_log_store.sv */
// Sticky four-word store of the header of the first uncorrectable error
module header_log_store
  import ext_cap_pkg::*;
#(
  parameter int WORDS = 4
)
(
  input wire logic clk,
  input wire logic por,
  input wire logic capture,
  input wire logic [WORDS*32-1:0] capture_hdr,
  input wire logic clear_first,
  output logic [WORDS*32-1:0] log_words,
  output logic log_held
);

  typedef struct packed {
    logic [WORDS*32-1:0] words;
    logic held;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // ----------------------------------------------------------------
  // Capture logic
  // ----------------------------------------------------------------
  // Only the first error is kept; later ones are ignored until a clear.
  // A capture in the same cycle as a clear wins, so it is not lost.
  always_comb
  begin
    st_nxt = st_r;
    if (clear_first)
    begin
      st_nxt.held = 1'b0;
    end
    if (capture && (!st_r.held || clear_first))
    begin
      st_nxt.words = capture_hdr;
      st_nxt.held = 1'b1;
    end
  end

  // Only power-on reset clears the store; warm resets leave it alone
  always_ff @(posedge clk)
  begin
    if (por)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign log_words = st_r.words;
  assign log_held = st_r.held;

endmodule : header_log_store

/* File: logic/cap_header_word.sv */
// Builds one extended capability header word from its three fields
module cap_header_word
  import ext_cap_pkg::*;
(
  input wire logic [15:0] cap_id,
  input wire logic [11:0] next_off,
  output logic [31:0] word
);

  // ----------------------------------------------------------------
  // Field packing
  // ----------------------------------------------------------------
  // Version is fixed; next offset zero ends the chain
  always_comb
  begin
    word = WORD_ZERO;
    word[CAP_ID_LSB +: CAP_ID_W] = cap_id;
    word[CAP_VER_LSB +: CAP_VER_W] = CAP_VERSION;
    word[NEXT_OFF_LSB +: NEXT_OFF_W] = next_off;
  end

endmodule : cap_header_word

/* File: logic/pcie_ext_capability_regs.sv */
// Extended capability register bank: error header log, serial number and channel capability
//
// Added by the designer: the strobed register port.
module pcie_ext_capability_regs
  import ext_cap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic hdr_capture,
  input wire logic [127:0] hdr_in,
  input wire logic hdr_release,
  output logic hdr_log_valid,
  output logic [1:0] arb_table_entry_size,
  output logic [2:0] extra_channel_count
);

  import ext_cap_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] unique_id_word_low;
    logic [31:0] unique_id_word_high;
    logic [11:0] serial_next_off;
    logic [11:0] channel_next_off;
    logic [2:0] extra_channel_count;
    logic [2:0] low_prio_extra_channel_count;
    logic [1:0] arb_table_entry_size;
    logic locked;
    logic [31:0] rdata;
    logic hdr_valid;
    logic [1:0] arb_out;
    logic [2:0] extra_out;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic [127:0] log_words;
  logic log_held;
  logic [31:0] serial_hdr;
  logic [31:0] channel_hdr;
  logic [31:0] port_caps_word;

  // ----------------------------------------------------------------
  // Sub-blocks
  // ----------------------------------------------------------------
  // Header store runs on power-on reset only, not the port reset
  header_log_store #(
    .WORDS(4)
  ) u_log (
    .clk(clk),
    .por(por),
    .capture(hdr_capture),
    .capture_hdr(hdr_in),
    .clear_first(hdr_release),
    .log_words(log_words),
    .log_held(log_held)
  );

  // Serial number capability header
  cap_header_word u_serial_hdr (
    .cap_id(SERIAL_CAP_ID),
    .next_off(st_r.serial_next_off),
    .word(serial_hdr)
  );

  // Virtual channel capability header
  cap_header_word u_channel_hdr (
    .cap_id(CHANNEL_CAP_ID),
    .next_off(st_r.channel_next_off),
    .word(channel_hdr)
  );

  // ----------------------------------------------------------------
  // Port channel capability word
  // ----------------------------------------------------------------
  // Reserved bits 3, 7 and 31:12 stay zero
  always_comb
  begin
    port_caps_word = WORD_ZERO;
    port_caps_word[EXTRA_CNT_LSB +: 3] = st_r.extra_channel_count;
    port_caps_word[LOW_PRIO_CNT_LSB +: 3] = st_r.low_prio_extra_channel_count;
    port_caps_word[WRR_BASE_LSB +: 2] = WRR_BASE_VALUE;
    port_caps_word[ARB_SIZE_LSB +: 2] = st_r.arb_table_entry_size;
  end

  // Read decode, shared by the read path
  function automatic logic [31:0] read_word(
    input logic [11:0] a,
    input state_s s,
    input logic [127:0] lw,
    input logic [31:0] sh,
    input logic [31:0] ch,
    input logic [31:0] pc
  );
    logic [31:0] v;
    v = WORD_ZERO;
    case (a)
      OFF_HDR_LOG_W1: v = lw[31:0];
      OFF_HDR_LOG_W2: v = lw[63:32];
      OFF_HDR_LOG_W3: v = lw[95:64];
      OFF_HDR_LOG_W4: v = lw[127:96];
      OFF_SERIAL_CAP_HEADER: v = sh;
      OFF_UNIQUE_ID_LOW: v = s.unique_id_word_low;
      OFF_UNIQUE_ID_HIGH: v = s.unique_id_word_high;
      OFF_CHANNEL_CAP_HEADER: v = ch;
      OFF_PORT_CHANNEL_CAPS_ONE: v = pc;
      OFF_LOAD_CTRL: v[LOAD_LOCK_BIT] = s.locked;
      default: v = WORD_ZERO; // Unmapped reads return zero
    endcase
    return v;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Load-once fields take writes until software sets the lock bit;
  // after that the whole block is read-only until reset.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = WORD_ZERO;
    if (rd)
    begin
      st_nxt.rdata = read_word(addr, st_r, log_words, serial_hdr, channel_hdr, port_caps_word);
    end
    if (wr && !st_r.locked)
    begin
      case (addr)
        OFF_SERIAL_CAP_HEADER: st_nxt.serial_next_off = wdata[NEXT_OFF_LSB +: NEXT_OFF_W];
        OFF_UNIQUE_ID_LOW: st_nxt.unique_id_word_low = wdata;
        OFF_UNIQUE_ID_HIGH: st_nxt.unique_id_word_high = wdata;
        OFF_CHANNEL_CAP_HEADER: st_nxt.channel_next_off = wdata[NEXT_OFF_LSB +: NEXT_OFF_W];
        OFF_PORT_CHANNEL_CAPS_ONE:
        begin
          st_nxt.extra_channel_count = wdata[EXTRA_CNT_LSB +: 3];
          st_nxt.low_prio_extra_channel_count = wdata[LOW_PRIO_CNT_LSB +: 3];
          st_nxt.arb_table_entry_size = wdata[ARB_SIZE_LSB +: 2];
        end
        OFF_LOAD_CTRL: st_nxt.locked = wdata[LOAD_LOCK_BIT];
        default: st_nxt.locked = st_r.locked; // Header log and others ignore writes
      endcase
    end
    st_nxt.hdr_valid = log_held;
    st_nxt.arb_out = st_nxt.arb_table_entry_size;
    st_nxt.extra_out = st_nxt.extra_channel_count;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Port reset restores load-once values; header log is held elsewhere
  always_ff @(posedge clk)
  begin
    if (rst || por)
    begin
      st_r <= '0;
      st_r.serial_next_off <= SERIAL_NEXT_RESET;
      st_r.channel_next_off <= CHANNEL_NEXT_RESET;
      st_r.extra_channel_count <= EXTRA_CNT_RESET;
      st_r.low_prio_extra_channel_count <= LOW_PRIO_CNT_RESET;
      st_r.arb_table_entry_size <= ARB_SIZE_RESET;
      st_r.arb_out <= ARB_SIZE_RESET;
      st_r.extra_out <= EXTRA_CNT_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from flip-flops
  assign rdata = st_r.rdata;
  assign hdr_log_valid = st_r.hdr_valid;
  assign arb_table_entry_size = st_r.arb_out;
  assign extra_channel_count = st_r.extra_out;

endmodule : pcie_ext_capability_regs

/* File: test/ext_cap_regs_monitor.sv */
// Checker of the extended capability register bank, bound to its ports
module ext_cap_regs_monitor
  import ext_cap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic hdr_capture,
  input wire logic [127:0] hdr_in,
  input wire logic hdr_release,
  input wire logic hdr_log_valid,
  input wire logic [1:0] arb_table_entry_size,
  input wire logic [2:0] extra_channel_count
);
  timeunit 1ns;
  timeprecision 1ps;
  import ext_cap_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por);
  // ----------------------------------------------------------------
  // Read answers
  // ----------------------------------------------------------------
  chk_serial_cap_id: assert property (rd && addr == OFF_SERIAL_CAP_HEADER |=> rdata[15:0] == SERIAL_CAP_ID)
    else $error("serial header id wrong");
  chk_cap_version_both: assert property (
    rd && (addr == OFF_SERIAL_CAP_HEADER || addr == OFF_CHANNEL_CAP_HEADER) |=> rdata[19:16] == 4'h1)
    else $error("capability version wrong");
  chk_channel_cap_id: assert property (rd && addr == OFF_CHANNEL_CAP_HEADER |=> rdata[15:0] == 16'h0002)
    else $error("channel header id wrong");
  chk_port_caps_reserved: assert property (rd && addr == OFF_PORT_CHANNEL_CAPS_ONE
    |=> rdata[31:12] == 20'h0 && rdata[9:7] == 3'h0 && rdata[3] == 1'b0)
    else $error("port channel reserved bits set");
  chk_arb_mirror_match: assert property (rd && addr == OFF_PORT_CHANNEL_CAPS_ONE
    |=> rdata[11:10] == arb_table_entry_size && rdata[2:0] == extra_channel_count)
    else $error("field copy differs from register");
  chk_unmapped_read_zero: assert property (rd && addr == 12'h0fc |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  // Read data stand only in the cycle after the strobe
  chk_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  // Warm reset may bring back a held log, so edges right after it are skipped
  chk_valid_has_cause: assert property ($rose(hdr_log_valid) && !$past(rst) && !$past(rst, 2)
    |-> $past(hdr_capture, 2))
    else $error("log valid without capture");
  cover property (wr && addr == OFF_LOAD_CTRL);
  cover property (hdr_capture && hdr_release);
  cover property (hdr_capture && hdr_log_valid);
  cover property (rd && addr == OFF_UNIQUE_ID_HIGH);
endmodule : ext_cap_regs_monitor

bind pcie_ext_capability_regs ext_cap_regs_monitor i_mon (.clk(clk), .rst(rst), .por(por), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hdr_capture(hdr_capture), .hdr_in(hdr_in),
  .hdr_release(hdr_release), .hdr_log_valid(hdr_log_valid), .arb_table_entry_size(arb_table_entry_size),
  .extra_channel_count(extra_channel_count));

/* File: test/pcie_ext_capability_regs_bench.sv */
// Self-checking bench of the extended capability register bank
module pcie_ext_capability_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_cap_pkg::*;
  logic clk = 0, rst = 1, por = 1, wr = 0, rd = 0, hdr_capture = 0, hdr_release = 0, hdr_log_valid;
  logic [11:0] addr = 12'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [127:0] hdr_in = 128'h0;
  logic [1:0] arb_table_entry_size;
  logic [2:0] extra_channel_count;
  int error_cnt = 0, checked = 0;
  logic [127:0] h1 = 128'h4444_0004_3333_0003_2222_0002_1111_0001;
  logic [127:0] h2 = 128'hdddd_8888_cccc_7777_bbbb_6666_aaaa_5555;
  pcie_ext_capability_regs i_dut (.clk(clk), .rst(rst), .por(por), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .hdr_capture(hdr_capture), .hdr_in(hdr_in), .hdr_release(hdr_release),
    .hdr_log_valid(hdr_log_valid), .arb_table_entry_size(arb_table_entry_size),
    .extra_channel_count(extra_channel_count));
  // 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic report_and_stop;
    $display("Counts: %0d checks, %0d mismatches", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Strobe lowered one edge later, so the next call leaves one idle cycle
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check($sformatf("reg %h", a), rdata, exp);
  endtask : rd_reg
  task automatic do_reset(input logic p);
    @(posedge clk);
    rst <= 1'b1;
    por <= p;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
  endtask : do_reset
  // Pulse capture, then wait bounded for the valid flag
  task automatic capture(input logic [127:0] h);
    int n;
    @(posedge clk);
    hdr_capture <= 1'b1;
    hdr_in <= h;
    @(posedge clk);
    hdr_capture <= 1'b0;
    for (n = 0; n < 8 && hdr_log_valid !== 1'b1; n++)
      @(posedge clk);
    if (n == 8)
    begin
      check("log valid wait", 32'h0, 32'h1);
      report_and_stop();
    end
  endtask : capture
  task automatic read_log(input logic [127:0] h);
    for (int i = 0; i < 4; i++)
      rd_reg(OFF_HDR_LOG_W1 + 12'(4 * i), h[32*i +: 32]);
  endtask : read_log
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    // Reset values of every register except the load control, and of an unmapped place
    read_log(128'h0);
    check("log valid", 32'(hdr_log_valid), 32'h0);
    check("extra count port", 32'(extra_channel_count), 32'h0);
    rd_reg(OFF_SERIAL_CAP_HEADER, 32'h2001_0003);
    rd_reg(OFF_UNIQUE_ID_LOW, 32'h0);
    rd_reg(OFF_UNIQUE_ID_HIGH, 32'h0);
    rd_reg(OFF_CHANNEL_CAP_HEADER, 32'h0001_0002);
    rd_reg(OFF_PORT_CHANNEL_CAPS_ONE, 32'h0000_0800);
    rd_reg(12'h0fc, 32'h0);
    check("arb size port", 32'(arb_table_entry_size), 32'h2);
    $display("Test reset values done");
    // Load-once fields take writes; read-only and reserved bits ignore them
    wr_reg(OFF_UNIQUE_ID_LOW, 32'h89ab_cdef);
    wr_reg(OFF_UNIQUE_ID_HIGH, 32'h0123_4567);
    rd_reg(OFF_UNIQUE_ID_LOW, 32'h89ab_cdef);
    rd_reg(OFF_UNIQUE_ID_HIGH, 32'h0123_4567);
    wr_reg(OFF_SERIAL_CAP_HEADER, 32'h000f_ffff);
    rd_reg(OFF_SERIAL_CAP_HEADER, 32'h0001_0003);
    wr_reg(OFF_PORT_CHANNEL_CAPS_ONE, 32'hffff_ffff);
    rd_reg(OFF_PORT_CHANNEL_CAPS_ONE, 32'h0000_0c77);
    check("extra count port", 32'(extra_channel_count), 32'h7);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(OFF_PORT_CHANNEL_CAPS_ONE, 32'(i) << 10);
      rd_reg(OFF_PORT_CHANNEL_CAPS_ONE, 32'(i) << 10);
      check("arb size port", 32'(arb_table_entry_size), 32'(i));
    end
    wr_reg(OFF_HDR_LOG_W2, 32'hffff_ffff);
    rd_reg(OFF_HDR_LOG_W2, 32'h0);
    // Lock freezes the identifier
    wr_reg(OFF_LOAD_CTRL, 32'h1);
    wr_reg(OFF_UNIQUE_ID_LOW, 32'h5555_aaaa);
    rd_reg(OFF_UNIQUE_ID_LOW, 32'h89ab_cdef);
    $display("Test load once done");
    // First error kept, second capture while held ignored
    capture(h1);
    read_log(h1);
    @(posedge clk);
    hdr_capture <= 1'b1;
    hdr_in <= h2;
    @(posedge clk);
    hdr_capture <= 1'b0;
    read_log(h1);
    // Warm reset keeps the log, power-on reset clears it
    do_reset(1'b0);
    read_log(h1);
    check("log valid", 32'(hdr_log_valid), 32'h1);
    @(posedge clk);
    hdr_release <= 1'b1;
    @(posedge clk);
    hdr_release <= 1'b0;
    capture(h2);
    read_log(h2);
    // Release and capture in one cycle: the new header is taken
    @(posedge clk);
    hdr_release <= 1'b1;
    hdr_capture <= 1'b1;
    hdr_in <= h1;
    @(posedge clk);
    hdr_release <= 1'b0;
    hdr_capture <= 1'b0;
    read_log(h1);
    check("log valid", 32'(hdr_log_valid), 32'h1);
    do_reset(1'b1);
    read_log(128'h0);
    check("log valid", 32'(hdr_log_valid), 32'h0);
    $display("Test header log done");
    report_and_stop();
  end
endmodule : pcie_ext_capability_regs_bench
